// ### dso_consts.svh
/*
 Constants for the deserializer output stage: register offsets, field
 positions, strap pin positions on the pixel bus and timing counts.
 Assumes the includer is compiled after this file, on a 25 MHz clock.
*/
`ifndef DSO_CONSTS_SVH
`define DSO_CONSTS_SVH

// ****************
// Register map
// ****************
`define DSO_ADDR_W        8
`define DSO_ADDR_CTRL     8'h00
`define DSO_ADDR_CFG      8'h04
`define DSO_ADDR_STATUS   8'h08
`define DSO_ADDR_STRAP    8'h0C
`define DSO_CTRL_RELEASE  0
`define DSO_ST_LOCK       0
`define DSO_ST_PASS       1
`define DSO_ST_OVR        2
`define DSO_ST_FSM_LSB    4
`define DSO_CFG_W         21

// ****************
// Modes and timing
// ****************
`define DSO_MODE_FILT     2'h1
`define DSO_CLK_NS        40
`define DSO_SETTLE_NS     400
`define DSO_SETTLE_CYC    ((`DSO_SETTLE_NS + `DSO_CLK_NS - 1) / `DSO_CLK_NS)
`define DSO_WAIT_W        4
`define DSO_FILT_MIN      3
`define DSO_FILT_W        2
`define DSO_SYNC_W        57

// ****************
// Strap positions: blue 0..7, green 8..15, red 16..23
// ****************
`define DSO_PIN_MODE1     6
`define DSO_PIN_MODE0     7
`define DSO_PIN_EQ3       15
`define DSO_PIN_EQ2       14
`define DSO_PIN_EQ1       13
`define DSO_PIN_EQ0       12
`define DSO_PIN_LF        4
`define DSO_PIN_MAP1      17
`define DSO_PIN_MAP0      16
`define DSO_PIN_OSDATA    3
`define DSO_PIN_OSC2      10
`define DSO_PIN_OSC1      9
`define DSO_PIN_OSC0      8
`define DSO_PIN_OSPCLK    5
`define DSO_PIN_OSS       2
`define DSO_PIN_RFB       1
`define DSO_PIN_SSC3      22
`define DSO_PIN_SSC2      21
`define DSO_PIN_SSC1      20
`define DSO_PIN_SSC0      19

`endif

// ### dso_pkg.sv
/*
 Types of the deserializer output stage: states and configuration word.
 Assumes dso_consts.svh is on the include path.
*/
`include "dso_consts.svh"

package dso_pkg;

	typedef enum logic [3:0] {
		ST_OFF    = 4'h1,
		ST_SAMPLE = 4'h2,
		ST_RUN    = 4'h4,
		ST_SLEEP  = 4'h8
	} dso_fsm_t;

	// Field order fixes the CFG register layout, msb first
	typedef struct packed {
		logic       strobe_edge_select;
		logic       oss;
		logic       ospclk;
		logic [2:0] osc;
		logic       osdata;
		logic       oplow;
		logic [1:0] map;
		logic       lf;
		logic [3:0] eq;
		logic [3:0] ssc;
		logic [1:0] mode;
	} dso_cfg_t;

endpackage

// ### dso_sync.sv
/*
 Two-flop synchroniser for a vector of unrelated levels.
 Assumes each bit is a slow level or is re-qualified downstream.
*/
`timescale 1ns/1ps
`default_nettype none

module dso_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	input  wire logic [W-1:0] i_d,
	output var  logic [W-1:0] o_q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			o_q    <= '0;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end

endmodule
`default_nettype wire

// ### dso_pulse_filter.sv
/*
 Minimum-width filter for one video control signal.
 Assumes i_tick is a one-cycle pixel clock edge strobe on i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dso_consts.svh"

module dso_pulse_filter (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_tick,
	input  wire logic i_en,
	input  wire logic i_in,
	output var  logic o_out
);

	typedef struct packed {
		logic                   out;
		logic [`DSO_FILT_W-1:0] cnt;
	} dso_filt_t;

	dso_filt_t s, n;

	always_comb begin
		n = s;
		if (i_tick) begin
			if (!i_en) begin
				n.out = i_in;
				n.cnt = '0;
			end else if (i_in == s.out) begin
				n.cnt = '0;
			end else if (s.cnt == `DSO_FILT_W'(`DSO_FILT_MIN - 1)) begin
				n.out = i_in;
				n.cnt = '0;
			end else begin
				n.cnt = s.cnt + `DSO_FILT_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign o_out = s.out;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	filt_min_a: assert property ($past(i_en) && $changed(o_out) |-> $past(s.cnt) == `DSO_FILT_W'(`DSO_FILT_MIN - 1))
		else $error("filtered edge passed before minimum width");
	filt_pass_a: assert property (!i_en && i_tick |=> o_out == $past(i_in))
		else $error("unfiltered edge not forwarded");

endmodule
`default_nettype wire

// ### dso_output_stage.sv
/*
 Parallel video output stage and power-up strap configuration of a serial
 link deserializer, with a plain register port.
 Assumes the receiver supplies recovered pixel clock, data, lock, self-test
 enable and error levels from outside this clock; pins resolved by the bench.
*/
// Notes on behaviour
// - Locked: lock high, video outputs driven.
// - Unlocked: lock low, outputs per sleep select.
// - Self-test pass high until payload error.
// - Power-down: outputs follow sleep select.
// - Outputs launched against selected pixel clock edge.
// - Straps sampled at power-up, pins then outputs.
// - Mode: 00/01 filter off/on, 10/11 legacy.
// - Low-freq select counts only with spreading on.
// - Hold-low keeps outputs low until released.
// - Without hold-low, outputs run once locked.
// - Before power-up, parallel outputs high-impedance.
// - Every strap setting overridable by register.
// - Filter drops hsync/enable pulses under 3.
// - Strobe select 1 rising, 0 falling edge.
// - Power-down holds control registers in reset.
`timescale 1ns/1ps
`default_nettype none
`include "dso_consts.svh"

module dso_output_stage
	import dso_pkg::*;
(
	input  wire logic                   i_clk,
	input  wire logic                   i_sys_rst,
	input  wire logic                   i_power_down_n,
	input  wire logic                   i_pll_lock,
	input  wire logic                   i_builtin_selftest_en,
	input  wire logic                   i_builtin_selftest_err,
	input  wire logic                   i_rx_pclk,
	input  wire logic [23:0]            i_rx_rgb,
	input  wire logic                   i_rx_hs,
	input  wire logic                   i_rx_vs,
	input  wire logic                   i_rx_de,
	input  wire logic [23:0]            i_rgb_pin,
	output var  logic [23:0]            o_rgb,
	output var  logic                   o_rgb_oe,
	output var  logic                   o_hs,
	output var  logic                   o_vs,
	output var  logic                   o_de,
	output var  logic                   o_pclk,
	output var  logic                   o_ctl_oe,
	output var  logic                   o_lock,
	input  wire logic                   i_pass_pin,
	output var  logic                   o_pass,
	output var  logic                   o_pass_oe,
	input  wire logic [`DSO_ADDR_W-1:0] i_reg_addr,
	input  wire logic [31:0]            i_reg_wdata,
	input  wire logic                   i_reg_wr,
	input  wire logic                   i_reg_rd,
	output var  logic [31:0]            o_reg_rdata,
	output var  logic [3:0]             o_rx_equalization_level,
	output var  logic [2:0]             o_oscillator_select,
	output var  logic                   o_data_slew_select,
	output var  logic                   o_clock_slew_select,
	output var  logic [3:0]             o_spread_spectrum_range,
	output var  logic                   o_spread_low_freq_select,
	output var  logic [1:0]             o_map_select,
	output var  logic [1:0]             o_link_mode
);

	// ****************
	// State
	// ****************
	typedef struct packed {
		dso_fsm_t               st;
		logic [`DSO_WAIT_W-1:0] wait_cnt;
		dso_cfg_t               strap;
		dso_cfg_t               ovr_val;
		logic                   ovr;
		logic                   release_hold;
		logic                   pclk_prev;
		logic [23:0]            cap_rgb;
		logic                   cap_vs;
		logic [23:0]            rgb;
		logic                   hs;
		logic                   vs;
		logic                   de;
		logic                   pclk;
		logic                   ctl_oe;
		logic                   rgb_oe;
		logic                   lock;
		logic                   pass;
		logic                   pass_oe;
		logic [31:0]            rdata;
	} dso_regs_t;

	localparam dso_regs_t RST = '{st: ST_OFF, pass: 1'h1, default: '0};

	dso_regs_t s, n;

	// ****************
	// Pin synchronisers
	// ****************
	logic [`DSO_SYNC_W-1:0] sy;
	logic        pd_s, pll_s, builtin_selftest_s, err_s, pclk_s, hs_s, vs_s, de_s, pass_pin_s;
	logic [23:0] rx_rgb_s, pin_rgb_s;

	dso_sync #(.W(`DSO_SYNC_W)) u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_d       ({i_power_down_n, i_pll_lock, i_builtin_selftest_en, i_builtin_selftest_err,
		             i_rx_pclk, i_rx_hs, i_rx_vs, i_rx_de, i_rx_rgb, i_rgb_pin, i_pass_pin}),
		.o_q       (sy)
	);

	assign {pd_s, pll_s, builtin_selftest_s, err_s, pclk_s, hs_s, vs_s, de_s, rx_rgb_s, pin_rgb_s, pass_pin_s} = sy;

	// ****************
	// Strap decode
	// ****************
	function automatic dso_cfg_t strap_of(input logic [23:0] p, input logic pass_pin);
		dso_cfg_t c;
		c.mode   = {p[`DSO_PIN_MODE1], p[`DSO_PIN_MODE0]};
		c.eq     = {p[`DSO_PIN_EQ3], p[`DSO_PIN_EQ2], p[`DSO_PIN_EQ1], p[`DSO_PIN_EQ0]};
		c.lf     = p[`DSO_PIN_LF];
		c.map    = {p[`DSO_PIN_MAP1], p[`DSO_PIN_MAP0]};
		c.oplow  = pass_pin;
		c.osdata = p[`DSO_PIN_OSDATA];
		c.osc    = {p[`DSO_PIN_OSC2], p[`DSO_PIN_OSC1], p[`DSO_PIN_OSC0]};
		c.ospclk = p[`DSO_PIN_OSPCLK];
		c.oss    = p[`DSO_PIN_OSS];
		c.strobe_edge_select    = p[`DSO_PIN_RFB];
		c.ssc    = {p[`DSO_PIN_SSC3], p[`DSO_PIN_SSC2], p[`DSO_PIN_SSC1], p[`DSO_PIN_SSC0]};
		return c;
	endfunction

	// ****************
	// Effective configuration
	// ****************
	dso_cfg_t cfg;
	logic     rise, fall, launch, spread_on, hs_f, de_f;

	assign cfg       = s.ovr ? s.ovr_val : s.strap;
	assign spread_on = |cfg.ssc;
	assign rise      = pclk_s & ~s.pclk_prev;
	assign fall      = ~pclk_s & s.pclk_prev;
	// Data moves on the edge opposite the strobe, so it is settled when sampled
	assign launch    = cfg.strobe_edge_select ? fall : rise;

	assign o_rx_equalization_level  = cfg.eq;
	assign o_oscillator_select      = cfg.osc;
	assign o_data_slew_select       = cfg.osdata;
	assign o_clock_slew_select      = cfg.ospclk;
	assign o_spread_spectrum_range  = cfg.ssc;
	assign o_spread_low_freq_select = spread_on & cfg.lf;
	assign o_map_select             = cfg.map;
	assign o_link_mode              = cfg.mode;

	// ****************
	// Control signal filters
	// ****************
	dso_pulse_filter u_filt_hs (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_tick    (rise),
		.i_en      (cfg.mode == `DSO_MODE_FILT),
		.i_in      (hs_s),
		.o_out     (hs_f)
	);

	dso_pulse_filter u_filt_de (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_tick    (rise),
		.i_en      (cfg.mode == `DSO_MODE_FILT),
		.i_in      (de_s),
		.o_out     (de_f)
	);

	// ****************
	// Next state
	// ****************
	always_comb begin
		n = s;
		n.pclk_prev = pclk_s;

		case (s.st)
			ST_OFF, ST_SLEEP: begin
				if (pd_s) begin
					n.st       = ST_SAMPLE;
					n.wait_cnt = '0;
				end
			end
			ST_SAMPLE: begin
				if (!pd_s) begin
					n.st = ST_OFF;
				end else if (s.wait_cnt == `DSO_WAIT_W'(`DSO_SETTLE_CYC - 1)) begin
					n.strap = strap_of(pin_rgb_s, pass_pin_s);
					n.st    = ST_RUN;
				end else begin
					n.wait_cnt = s.wait_cnt + `DSO_WAIT_W'(1);
				end
			end
			ST_RUN: begin
				if (!pd_s) begin
					n.st = ST_SLEEP;
				end
			end
			default: begin
				n.st = ST_OFF;
			end
		endcase

		// Register writes; power-down wipes software control
		if (!pd_s) begin
			n.ovr          = 1'h0;
			n.release_hold = 1'h0;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`DSO_ADDR_CTRL: begin
					n.release_hold = i_reg_wdata[`DSO_CTRL_RELEASE];
				end
				`DSO_ADDR_CFG: begin
					n.ovr_val = dso_cfg_t'(i_reg_wdata[`DSO_CFG_W-1:0]);
					n.ovr     = 1'h1;
				end
				default: begin
				end
			endcase
		end

		// Register reads, answered in the following cycle
		n.rdata = 32'h0000_0000;
		if (i_reg_rd) begin
			case (i_reg_addr)
				`DSO_ADDR_CTRL: begin
					n.rdata[`DSO_CTRL_RELEASE] = s.release_hold;
				end
				`DSO_ADDR_CFG: begin
					n.rdata[`DSO_CFG_W-1:0] = cfg;
				end
				`DSO_ADDR_STATUS: begin
					n.rdata[`DSO_ST_LOCK]                     = s.lock;
					n.rdata[`DSO_ST_PASS]                     = s.pass;
					n.rdata[`DSO_ST_OVR]                      = s.ovr;
					n.rdata[`DSO_ST_FSM_LSB+3:`DSO_ST_FSM_LSB] = s.st;
				end
				`DSO_ADDR_STRAP: begin
					n.rdata[`DSO_CFG_W-1:0] = s.strap;
				end
				default: begin
				end
			endcase
		end

		// Capture recovered pixel on link clock rising edge
		if (rise) begin
			n.cap_rgb = rx_rgb_s;
			n.cap_vs  = vs_s;
		end

		n.lock = (s.st == ST_RUN) && pll_s;

		// Self-test verdict; errors only count while enabled
		if (!builtin_selftest_s) begin
			n.pass = 1'h1;
		end else if (err_s && rise) begin
			n.pass = 1'h0;
		end
		// Pass pin doubles as a strap, so it stays an input until sampled
		n.pass_oe = (s.st == ST_RUN);

		// Output pins
		n.rgb_oe = 1'h0;
		n.ctl_oe = 1'h0;
		if (s.st == ST_SLEEP || (s.st == ST_RUN && !pll_s)) begin
			n.rgb_oe                          = !cfg.oss;
			n.ctl_oe                          = !cfg.oss;
			{n.rgb, n.hs, n.vs, n.de, n.pclk} = '0;
		end else if (s.st == ST_RUN && cfg.oplow && !s.release_hold) begin
			// Sleep select ignored here, hold-low owns the pins
			n.rgb_oe                          = 1'h1;
			n.ctl_oe                          = 1'h1;
			{n.rgb, n.hs, n.vs, n.de, n.pclk} = '0;
		end else if (s.st == ST_RUN) begin
			n.rgb_oe = 1'h1;
			n.ctl_oe = 1'h1;
			n.pclk   = pclk_s;
			if (launch) begin
				n.rgb = s.cap_rgb;
				n.hs  = hs_f;
				n.vs  = s.cap_vs;
				n.de  = de_f;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s <= RST;
		end else begin
			s <= n;
		end
	end

	// ****************
	// Outputs
	// ****************
	assign o_rgb       = s.rgb;
	assign o_rgb_oe    = s.rgb_oe;
	assign o_hs        = s.hs;
	assign o_vs        = s.vs;
	assign o_de        = s.de;
	assign o_pclk      = s.pclk;
	assign o_ctl_oe    = s.ctl_oe;
	assign o_lock      = s.lock;
	assign o_pass      = s.pass;
	assign o_pass_oe   = s.pass_oe;
	assign o_reg_rdata = s.rdata;

	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence strap_window;
		s.st == ST_SAMPLE && n.st == ST_RUN;
	endsequence

	sequence run_steady;
		s.st == ST_RUN ##1 s.st == ST_RUN;
	endsequence

	lock_high_a: assert property (s.st == ST_RUN && pll_s |=> o_lock)
		else $error("lock not raised while locked");
	lock_low_a: assert property (!pll_s |=> !o_lock)
		else $error("lock high without pll lock");
	pass_drop_a: assert property (builtin_selftest_s && err_s && rise |=> !o_pass)
		else $error("pass held after payload error");
	sleep_state_a: assert property (s.st == ST_SLEEP |=> o_ctl_oe == !$past(cfg.oss) && !o_pclk)
		else $error("sleep outputs not per sleep select");
	launch_edge_a: assert property ($past(s.st) == ST_RUN && $changed(o_rgb) && o_rgb_oe
		&& $past(o_rgb_oe) |-> $past(launch) || $past(!pll_s) || $past(cfg.oplow))
		else $error("data changed off launch edge");
	strap_take_a: assert property (strap_window |=> s.strap == $past(strap_of(pin_rgb_s, pass_pin_s)))
		else $error("straps not latched at sampling");
	hold_low_a: assert property (s.st == ST_RUN && pll_s && cfg.oplow && !s.release_hold
		|=> o_rgb == 24'h00_0000 && !o_pclk && o_rgb_oe)
		else $error("outputs not held low");
	tri_state_a: assert property (s.st == ST_OFF || s.st == ST_SAMPLE |=> !o_rgb_oe && !o_ctl_oe && !o_pass_oe)
		else $error("pins driven before power-up");
	reg_reset_a: assert property (!pd_s |=> !s.ovr && !s.release_hold)
		else $error("control registers kept in power-down");
	strap_hold_a: assert property (run_steady |-> $stable(s.strap))
		else $error("straps changed while running");
	lf_ignore_a: assert property (!spread_on |-> !o_spread_low_freq_select)
		else $error("low-freq select used without spreading");
	ovr_cfg_a: assert property (pd_s && i_reg_wr && i_reg_addr == `DSO_ADDR_CFG
		|=> cfg == $past(i_reg_wdata[`DSO_CFG_W-1:0]))
		else $error("register override not applied");

endmodule
`default_nettype wire

// ### dso_pad_model.sv
/*
 Pad and strap model of the board around the output stage: resistors on the
 shared pixel pads and on the pass pad, resolved against the stage's drivers.
 Assumes the bench gives the strap word and the hold-low strap level.
*/
`timescale 1ns/1ps
`default_nettype none

module dso_pad_model (
	input  wire logic [23:0] i_strap,
	input  wire logic        i_hold_strap,
	input  wire logic [23:0] i_rgb,
	input  wire logic        i_rgb_oe,
	input  wire logic        i_pass,
	input  wire logic        i_pass_oe,
	output var  logic [23:0] o_rgb_pin,
	output var  logic        o_pass_pin
);
	// ****************
	// Pad resolution
	// ****************
	// Undriven pads fall back to their pull resistor, never the last value
	always_comb begin
		o_rgb_pin  = i_rgb_oe ? i_rgb : i_strap;
		o_pass_pin = i_pass_oe ? i_pass : i_hold_strap;
	end
endmodule
`default_nettype wire

// ### dso_output_stage_bench.sv
/*
 Self-checking bench of the output stage: straps, video, self-test, sleep.
 Assumes the design files and dso_pad_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dso_consts.svh"

module dso_output_stage_bench;
	import dso_pkg::*;
	logic        clk = 0, rst = 1, pdn = 0, pll = 0, st_en = 0, st_err = 0, rx_pclk = 0;
	logic        rx_hs = 0, rx_vs = 0, rx_de = 0, wr = 0, rd = 0, hold_strap = 0;
	logic [23:0] rx_rgb = 24'h00_0000, rgb_pin, o_rgb;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, d;
	logic        rgb_oe, o_hs, o_vs, o_de, o_pclk, ctl_oe, o_lock, pass_pin, o_pass, pass_oe;
	logic [3:0]  eq, ssc;
	logic [2:0]  osc;
	logic [1:0]  map, mode;
	logic        dslew, cslew, lf;
	int          num_errors = 0, cmp_count = 0, cycles = 0;
	dso_cfg_t    c;
	// Strap word: mode 01, eq a, osc 5, low-freq 1, data slew 1, strobe 1
	localparam logic [23:0] STRAP = 24'h00_A59A;

	// ****************
	// Clocks and instances
	// ****************
	initial begin
		forever #20 clk = ~clk;
	end
	// Link clock free-running, offset so its phase is unrelated
	initial begin
		#13;
		forever #160 rx_pclk = ~rx_pclk;
	end

	dso_pad_model pads (.i_strap(STRAP), .i_hold_strap(hold_strap), .i_rgb(o_rgb), .i_rgb_oe(rgb_oe),
		.i_pass(o_pass), .i_pass_oe(pass_oe), .o_rgb_pin(rgb_pin), .o_pass_pin(pass_pin));

	dso_output_stage dut (.i_clk(clk), .i_sys_rst(rst), .i_power_down_n(pdn), .i_pll_lock(pll),
		.i_builtin_selftest_en(st_en), .i_builtin_selftest_err(st_err), .i_rx_pclk(rx_pclk),
		.i_rx_rgb(rx_rgb), .i_rx_hs(rx_hs), .i_rx_vs(rx_vs), .i_rx_de(rx_de), .i_rgb_pin(rgb_pin),
		.o_rgb(o_rgb), .o_rgb_oe(rgb_oe), .o_hs(o_hs), .o_vs(o_vs), .o_de(o_de), .o_pclk(o_pclk),
		.o_ctl_oe(ctl_oe), .o_lock(o_lock), .i_pass_pin(pass_pin), .o_pass(o_pass),
		.o_pass_oe(pass_oe), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .o_rx_equalization_level(eq), .o_oscillator_select(osc),
		.o_data_slew_select(dslew), .o_clock_slew_select(cslew), .o_spread_spectrum_range(ssc),
		.o_spread_low_freq_select(lf), .o_map_select(map), .o_link_mode(mode));

	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 v = rdata;
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	// ****************
	// Scenarios
	// ****************
	task automatic t_power_up(input logic hold);
		int n;
		@(posedge clk);
		hold_strap <= hold;
		pdn        <= 1'h1;
		cyc(8);
		chk("rgb_oe in sample", rgb_oe, 0);
		n = 0;
		while (rgb_oe !== 1'h1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk("rgb_oe after sample", rgb_oe, 1);
		reg_rd(`DSO_ADDR_STRAP, d);
		c = '{strobe_edge_select:1'h1, oss:1'h0, ospclk:1'h0, osc:3'h5, osdata:1'h1, oplow:hold, map:2'h0,
			lf:1'h1, eq:4'ha, ssc:4'h0, mode:2'h1};
		chk("strap word", d[20:0], c);
		chk("mode", mode, 2'h1);
		chk("eq osc", {eq, osc, dslew, cslew, map}, {4'ha, 3'h5, 1'h1, 1'h0, 2'h0});
		chk("low freq ignored", lf, 0);
		reg_rd(`DSO_ADDR_STATUS, d);
		chk("override clear", d[2], 0);
		$display("test power_up done");
	endtask

	task automatic hs_pulse(input int w, input logic exp);
		logic seen;
		seen = 1'h0;
		@(posedge clk);
		rx_hs <= 1'h1;
		// Looked at on the falling edge, clear of the launching edge
		repeat (w) begin
			@(negedge clk);
			seen = seen | o_hs;
		end
		@(posedge clk);
		rx_hs <= 1'h0;
		repeat (60) begin
			@(negedge clk);
			seen = seen | o_hs;
		end
		chk("hs passed", seen, exp);
	endtask

	task automatic t_video;
		@(posedge clk);
		pll    <= 1'h1;
		rx_rgb <= 24'h12_3456;
		rx_vs  <= 1'h1;
		rx_de  <= 1'h1;
		cyc(60);
		chk("lock", o_lock, 1);
		chk("vs de", {o_vs, o_de}, 2'h3);
		chk("pixel", o_rgb, 24'h12_3456);
		chk("ctl_oe", ctl_oe, 1);
		// Filter on from the strap: one pclk is too short, five pass
		hs_pulse(10, 1'h0);
		hs_pulse(40, 1'h1);
		$display("test video done");
	endtask

	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			c.mode = m[1:0];
			c.ssc  = m[3:0];
			reg_wr(`DSO_ADDR_CFG, {11'h000, c});
			cyc(1);
			chk("link mode", mode, m[1:0]);
			chk("low freq", lf, m != 0);
			reg_rd(`DSO_ADDR_STATUS, d);
			chk("override set", d[2], 1);
		end
		c.mode = 2'h0;
		reg_wr(`DSO_ADDR_CFG, {11'h000, c});
		hs_pulse(10, 1'h1);
		reg_rd(8'h10, d);
		chk("unmapped", d, 0);
		$display("test modes done");
	endtask

	task automatic t_selftest;
		@(posedge clk);
		st_en <= 1'h1;
		cyc(30);
		chk("pass clean", o_pass, 1);
		@(posedge clk);
		st_err <= 1'h1;
		cyc(20);
		@(posedge clk);
		st_err <= 1'h0;
		cyc(20);
		chk("pass after error", o_pass, 0);
		@(posedge clk);
		st_en <= 1'h0;
		cyc(10);
		chk("pass restored", o_pass, 1);
		$display("test selftest done");
	endtask

	task automatic t_sleep;
		@(posedge clk);
		pll <= 1'h0;
		cyc(20);
		chk("lock low", o_lock, 0);
		chk("sleep driven low", {rgb_oe, ctl_oe, o_rgb, o_pclk}, {2'h3, 25'h0});
		c.oss = 1'h1;
		reg_wr(`DSO_ADDR_CFG, {11'h000, c});
		cyc(2);
		chk("unlocked undriven", {rgb_oe, ctl_oe}, 2'h0);
		@(posedge clk);
		pdn <= 1'h0;
		cyc(20);
		// Power-down wipes the override, so the strap sleep select rules
		chk("power down strap", {rgb_oe, ctl_oe, o_rgb, o_pclk}, {2'h3, 25'h0});
		$display("test sleep done");
	endtask

	task automatic t_hold_low;
		t_power_up(1'h1);
		@(posedge clk);
		pll <= 1'h1;
		cyc(60);
		chk("held low", {rgb_oe, o_rgb}, {1'h1, 24'h00_0000});
		reg_wr(`DSO_ADDR_CTRL, 32'h0000_0001);
		cyc(60);
		chk("released", o_rgb, 24'h12_3456);
		$display("test hold_low done");
	endtask

	task automatic t_reset;
		cyc(7);
		chk("reset oe", {rgb_oe, ctl_oe, pass_oe, o_lock, o_pass}, 5'h01);
		@(posedge clk);
		rst <= 1'h0;
		cyc(4);
		chk("off undriven", {rgb_oe, ctl_oe}, 2'h0);
		reg_rd(`DSO_ADDR_STATUS, d);
		chk("fsm off", d[7:4], 4'h1);
		$display("test reset done");
	endtask

	initial begin
		t_reset();
		t_power_up(1'h0);
		t_video();
		t_modes();
		t_selftest();
		t_sleep();
		t_hold_low();
		tally_and_finish();
	end
endmodule
`default_nettype wire
